// file: frame_acquisition_sequencer.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module frame_acquisition_sequencer
    import acq_seq_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    // Camera and external events.
    input wire logic frame_valid,
    input wire logic line_valid,
    input wire logic trigger,
    input wire logic encoder,
    input wire logic lineWindowEnd,
    input wire logic line_table_clear_event,
    input wire logic line_table_load_enable,
    input wire logic software_clear_event,
    // Results.
    output logic frameMarked,
    output logic [COUNT_WIDTH-1:0] line_position_counter
);

    ////////////////////////////////////////////////////////////////////////////

    logic [3:0] syncLevel;
    logic [3:0] syncRise;
    logic [3:0] syncFall;

    // Bit order: frame valid, line valid, trigger, encoder.
    edge_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async({frame_valid, line_valid, trigger, encoder}),
        .level(syncLevel),
        .rise(syncRise),
        .fall(syncFall)
    );

    logic vertical_active;
    logic frame_valid_rise_event;
    logic line_valid_rise_event;
    logic trigLevel;
    logic trigRise;
    logic trigger_fall_event;
    logic encoder_rise_event;

    assign vertical_active = syncLevel[3];
    assign frame_valid_rise_event = syncRise[3];
    assign line_valid_rise_event = syncRise[2];
    assign trigLevel = syncLevel[1];
    assign trigRise = syncRise[1];
    assign trigger_fall_event = syncFall[1];
    assign encoder_rise_event = syncRise[0];

    ////////////////////////////////////////////////////////////////////////////

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_CAPTURE = 2'b10,
        ST_STOPPING = 2'b11
    } acq_state_t;

    typedef struct packed {
        capture_cmd_t pendingCmd;
        capture_cmd_t activeCmd;
        logic [11:0] control;
        acq_state_t state;
        logic trigArmed;
        logic heldZero;
        logic [COUNT_WIDTH-1:0] count;
        logic [31:0] rdData;
    } state_t;

    state_t r;
    state_t next_r;

    logic [2:0] capture_mode_select;
    logic abort_source_select;
    logic line_zero_release_select;
    logic line_stick_release_select;
    logic [1:0] line_counter_clear_select;
    logic [1:0] line_counter_jump_select;

    assign capture_mode_select = r.control[CTL_MODE_LSB +: 3];
    assign abort_source_select = r.control[CTL_ABORT_SRC];
    assign line_zero_release_select = r.control[CTL_ZERO_REL];
    assign line_stick_release_select = r.control[CTL_STICK_REL];
    assign line_counter_clear_select = r.control[CTL_CLEAR_LSB +: 2];
    assign line_counter_jump_select = r.control[CTL_JUMP_LSB +: 2];

    logic cmdWrite;
    logic host_stop_write_event;
    logic abortNow;
    logic line_clear_event;
    logic line_jump_event;
    logic running;

    assign cmdWrite = regWrite && (regAddr == ADDR_COMMAND);
    assign host_stop_write_event = cmdWrite && (regWrData[1:0] == CMD_ABORT)
        && (capture_mode_select != MODE_TRIG_LEVEL);
    assign abortNow = host_stop_write_event
        || (abort_source_select && trigger_fall_event);
    assign running = (r.state == ST_CAPTURE) && (r.activeCmd inside {CMD_SNAP, CMD_GRAB});

    always_comb
    begin
        case (line_counter_clear_select)
            CLEAR_END_WINDOW: line_clear_event = lineWindowEnd;
            CLEAR_FRAME_OR_TABLE: line_clear_event = frame_valid_rise_event
                || line_table_clear_event;
            CLEAR_TABLE: line_clear_event = line_table_clear_event;
            default: line_clear_event = 1'b0;
        endcase
        case (line_counter_jump_select)
            JUMP_LINE_VALID: line_jump_event = line_valid_rise_event
                && line_table_load_enable;
            JUMP_ENCODER: line_jump_event = encoder_rise_event
                && line_table_load_enable;
            default: line_jump_event = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        next_r = r;
        next_r.rdData = 32'h0000_0000;

        if (regRead)
        begin
            case (regAddr)
                ADDR_COMMAND: next_r.rdData = {30'h0, r.pendingCmd};
                ADDR_CONTROL: next_r.rdData = {20'h0, r.control};
                ADDR_STATUS: next_r.rdData = {28'h0, r.state, r.activeCmd};
                ADDR_COUNTER: next_r.rdData = {18'h0, r.count};
                default: next_r.rdData = 32'h0000_0000;
            endcase
        end
        if (regWrite && (regAddr == ADDR_CONTROL))
        begin
            next_r.control = regWrData[11:0];
        end

        // Line position counter; clears win over a jump, a jump over the zero hold and the stick point.
        if (software_clear_event || host_stop_write_event)
        begin
            next_r.count = COUNT_RESET;
            next_r.heldZero = line_zero_release_select;
        end
        else if (line_clear_event)
        begin
            next_r.count = COUNT_RESET;
            next_r.heldZero = line_zero_release_select;
        end
        else if (line_jump_event)
        begin
            next_r.count = JUMP_VALUE;
            next_r.heldZero = 1'b0;
        end
        else if (r.heldZero && line_zero_release_select && !encoder_rise_event)
        begin
            next_r.count = COUNT_RESET;
        end
        else if (line_stick_release_select && (r.count == STICK_POINT))
        begin
            next_r.count = STICK_POINT;
        end
        else
        begin
            next_r.count = r.count + 1'b1;
            next_r.heldZero = 1'b0;
        end

        // Host command latch; held until a frame start takes a snap or a MODE_TRIG_CMD command, or until an abort.
        if (cmdWrite && (capture_mode_select != MODE_TRIG_LEVEL))
        begin
            if (!((regWrData[1] == 1'b1) && running))
            begin
                next_r.pendingCmd = capture_cmd_t'(regWrData[1:0]);
                next_r.trigArmed = 1'b0;
            end
        end
        if (trigRise)
        begin
            next_r.trigArmed = 1'b1;
        end

        // Acquisition state machine.
        case (r.state)
            ST_IDLE, ST_WAIT:
            begin
                if (capture_mode_select == MODE_TRIG_LEVEL)
                begin
                    next_r.state = ST_WAIT;
                    if (frame_valid_rise_event && trigLevel)
                    begin
                        next_r.activeCmd = CMD_GRAB;
                        next_r.state = ST_CAPTURE;
                    end
                end
                else if (frame_valid_rise_event && next_r.pendingCmd[1]
                    && ((capture_mode_select == MODE_NEXT_FRAME)
                    || r.trigArmed || trigRise))
                begin
                    next_r.activeCmd = next_r.pendingCmd;
                    next_r.state = ST_CAPTURE;
                    next_r.trigArmed = 1'b0;
                    if ((next_r.pendingCmd == CMD_SNAP)
                        || (capture_mode_select == MODE_TRIG_CMD))
                    begin
                        next_r.pendingCmd = CMD_FREEZE;
                    end
                    if (capture_mode_select == MODE_TRIG_SNAP)
                    begin
                        next_r.activeCmd = CMD_SNAP;
                    end
                end
                else if (frame_valid_rise_event)
                begin
                    next_r.activeCmd = CMD_FREEZE;
                    next_r.state = ST_IDLE;
                end
            end
            ST_CAPTURE:
            begin
                if (!vertical_active || ((capture_mode_select == MODE_TRIG_LEVEL) && !trigLevel))
                begin
                    if ((r.activeCmd == CMD_SNAP) || (next_r.pendingCmd == CMD_FREEZE)
                        || (capture_mode_select != MODE_NEXT_FRAME))
                    begin
                        next_r.state = ST_STOPPING;
                    end
                    else
                    begin
                        next_r.state = ST_WAIT;
                    end
                end
            end
            ST_STOPPING:
            begin
                next_r.activeCmd = CMD_FREEZE;
                next_r.state = ST_IDLE;
            end
            default: next_r.state = ST_IDLE;
        endcase

        // Freeze between frames stops a continuous grab immediately.
        if ((r.state == ST_WAIT) && (next_r.pendingCmd == CMD_FREEZE)
            && (capture_mode_select == MODE_NEXT_FRAME) && !frame_valid_rise_event)
        begin
            next_r.activeCmd = CMD_FREEZE;
            next_r.state = ST_IDLE;
        end

        if (abortNow)
        begin
            next_r.state = ST_IDLE;
            next_r.activeCmd = CMD_ABORT;
            next_r.pendingCmd = CMD_FREEZE;
            next_r.trigArmed = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r.pendingCmd <= CMD_FREEZE;
            r.activeCmd <= CMD_FREEZE;
            r.control <= CTL_RESET;
            r.state <= ST_IDLE;
            r.trigArmed <= 1'b0;
            r.heldZero <= 1'b0;
            r.count <= COUNT_RESET;
            r.rdData <= 32'h0000_0000;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Marks the frame; window logic elsewhere picks pixels and lines.
    assign frameMarked = (r.state == ST_CAPTURE) && vertical_active;
    assign line_position_counter = r.count;
    assign regRdData = r.rdData;

    ////////////////////////////////////////////////////////////////////////////

    a_abort_stops: assert property (@(posedge clk) disable iff (!rst_n)
        abortNow |=> (r.state == ST_IDLE) && !frameMarked)
        else $error("abort did not stop capture");
    a_trig_abort_src: assert property (@(posedge clk) disable iff (!rst_n)
        (trigger_fall_event && abort_source_select && r.state == ST_CAPTURE)
        |=> r.state == ST_IDLE)
        else $error("trigger fall abort ignored");
    a_counter_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (software_clear_event || host_stop_write_event) |=> r.count == COUNT_RESET)
        else $error("counter not cleared");
    a_stick_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (r.count == STICK_POINT && line_stick_release_select && !line_clear_event
        && !line_jump_event && !software_clear_event && !host_stop_write_event
        && !(r.heldZero && line_zero_release_select))
        |=> r.count == STICK_POINT)
        else $error("counter left stick point");
    a_jump_value: assert property (@(posedge clk) disable iff (!rst_n)
        (line_jump_event && !line_clear_event && !software_clear_event
        && !host_stop_write_event) |=> r.count == JUMP_VALUE)
        else $error("counter did not jump");
    a_start_at_frame: assert property (@(posedge clk) disable iff (!rst_n)
        (r.state != ST_CAPTURE) ##1 (r.state == ST_CAPTURE)
        |-> $past(frame_valid_rise_event))
        else $error("capture began outside frame start");
    a_snap_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (r.state == ST_CAPTURE && $changed(r.state) && r.activeCmd == CMD_SNAP
        && capture_mode_select == MODE_NEXT_FRAME && !cmdWrite)
        |-> r.pendingCmd == CMD_FREEZE)
        else $error("snap did not clear command");
    a_ignore_busy: assert property (@(posedge clk) disable iff (!rst_n)
        (cmdWrite && regWrData[1] && running && !abortNow)
        |=> $stable(r.pendingCmd))
        else $error("busy command not ignored");
    a_level_mode: assert property (@(posedge clk) disable iff (!rst_n)
        (capture_mode_select == MODE_TRIG_LEVEL && cmdWrite && !abortNow
        && !(r.state == ST_CAPTURE && frame_valid_rise_event))
        |=> $stable(r.pendingCmd))
        else $error("command taken in level mode");

    c_snap: cover property (@(posedge clk) r.state == ST_CAPTURE && r.activeCmd == CMD_SNAP);
    c_grab: cover property (@(posedge clk) r.state == ST_CAPTURE && r.activeCmd == CMD_GRAB);
    c_abort: cover property (@(posedge clk) abortNow && r.state == ST_CAPTURE);
    c_stick: cover property (@(posedge clk) r.count == STICK_POINT);

endmodule : frame_acquisition_sequencer

`default_nettype wire

// file: acq_seq_pkg.sv
package acq_seq_pkg;

    // Capture commands.
    typedef enum logic [1:0] {
        CMD_FREEZE = 2'b00,
        CMD_ABORT = 2'b01,
        CMD_SNAP = 2'b10,
        CMD_GRAB = 2'b11
    } capture_cmd_t;

    // Capture mode select values.
    localparam logic [2:0] MODE_NEXT_FRAME = 3'h0;
    localparam logic [2:0] MODE_TRIG_CMD = 3'h1;
    localparam logic [2:0] MODE_TRIG_SNAP = 3'h2;
    localparam logic [2:0] MODE_TRIG_LEVEL = 3'h3;

    // Line counter selects and constants.
    localparam logic [1:0] CLEAR_END_WINDOW = 2'h0;
    localparam logic [1:0] CLEAR_FRAME_OR_TABLE = 2'h1;
    localparam logic [1:0] CLEAR_TABLE = 2'h2;
    localparam logic [1:0] JUMP_NONE = 2'h0;
    localparam logic [1:0] JUMP_LINE_VALID = 2'h1;
    localparam logic [1:0] JUMP_ENCODER = 2'h2;
    localparam int COUNT_WIDTH = 14;
    localparam logic [13:0] STICK_POINT = 14'h1ff0;
    localparam logic [13:0] JUMP_VALUE = 14'h2000;
    localparam logic [13:0] COUNT_RESET = 14'h0000;

    // Register map of the plain register port.
    localparam logic [3:0] ADDR_COMMAND = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_COUNTER = 4'h3;

    // Control register field positions.
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_ABORT_SRC = 4;
    localparam int CTL_ZERO_REL = 5;
    localparam int CTL_STICK_REL = 6;
    localparam int CTL_CLEAR_LSB = 8;
    localparam int CTL_JUMP_LSB = 10;
    localparam logic [11:0] CTL_RESET = 12'h000;

endpackage : acq_seq_pkg

// file: edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

module edge_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous inputs and synchronised results.
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } state_t;

    if (WIDTH < 1)
    begin : g_width_check
        $error("edge_sync needs a positive width");
    end

    state_t r;
    state_t next_r;

    always_comb
    begin
        next_r.meta = async;
        next_r.sync = r.meta;
        next_r.prev = r.sync;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign level = r.sync;
    assign rise = r.sync & ~r.prev;
    assign fall = ~r.sync & r.prev;

endmodule : edge_sync

`default_nettype wire

// file: camera_model.sv
`timescale 1ns/1ps
`default_nettype none

module camera_model (
    // Camera timing and events.
    output logic frame_valid,
    output logic line_valid,
    output logic trigger,
    output logic encoder
);
    // The camera's own line clock, 64 ns, with no phase tie to the block clock.
    logic lineClk = 1'b0;

    initial
    begin
        frame_valid = 1'b0;
        line_valid = 1'b0;
        trigger = 1'b0;
        encoder = 1'b0;
        #3;
        forever #32 lineClk = ~lineClk;
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Whole lines only, with both valid signals low between frames.
    task automatic frame(input int lines);
        @(posedge lineClk) frame_valid <= 1'b1;
        repeat (lines)
        begin
            @(posedge lineClk) line_valid <= 1'b1;
            repeat (8) @(posedge lineClk);
            line_valid <= 1'b0;
            repeat (2) @(posedge lineClk);
        end
        frame_valid <= 1'b0;
        repeat (4) @(posedge lineClk);
    endtask : frame

    task automatic setTrigger(input logic v);
        @(posedge lineClk) trigger <= v;
    endtask : setTrigger

    task automatic encPulse();
        @(posedge lineClk) encoder <= 1'b1;
        @(posedge lineClk) encoder <= 1'b0;
    endtask : encPulse

endmodule : camera_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import acq_seq_pkg::*;
    logic clk;
    logic rst_n;
    logic [3:0] regAddr;
    logic [31:0] regWrData;
    logic regWrite;
    logic regRead;
    logic [31:0] regRdData;
    logic [2:0] ev;
    logic loadEn;
    logic fv, lv, trig, enc, frameMarked;
    logic [COUNT_WIDTH-1:0] cnt;
    int errTotal = 0;
    int nCompared = 0;
    int cyc = 0;
    int seen;

    always #4 clk = ~clk;

    camera_model cam (.frame_valid(fv), .line_valid(lv), .trigger(trig), .encoder(enc));

    frame_acquisition_sequencer u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .frame_valid(fv), .line_valid(lv), .trigger(trig), .encoder(enc),
        .lineWindowEnd(ev[0]), .line_table_clear_event(ev[1]), .line_table_load_enable(loadEn),
        .software_clear_event(ev[2]), .frameMarked(frameMarked), .line_position_counter(cnt));

    ////////////////////////////////////////////////////////////////////////////////

    task automatic printVerdict();
        if (errTotal == 0 && nCompared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : printVerdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp)
        begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            errTotal++;
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rdChk(input string what, input logic [3:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(what, exp, regRdData & m);
    endtask : rdChk

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask : pulse

    function automatic logic [31:0] ctl(input logic [2:0] mode, input logic asrc, zr, st,
        input logic [1:0] clr, jmp);
        logic [31:0] v;
        v = 32'h0;
        v[CTL_MODE_LSB +: 3] = mode;
        v[CTL_ABORT_SRC] = asrc;
        v[CTL_ZERO_REL] = zr;
        v[CTL_STICK_REL] = st;
        v[CTL_CLEAR_LSB +: 2] = clr;
        v[CTL_JUMP_LSB +: 2] = jmp;
        return v;
    endfunction : ctl

    task automatic waitMark(input logic val, input int bound);
        for (int i = 0; i < bound && frameMarked !== val; i++) @(posedge clk) #1;
        chk("frameMarked", {31'h0, val}, {31'h0, frameMarked});
    endtask : waitMark

    task automatic frameSeen(input int lines, output int n);
        n = 0;
        fork
            cam.frame(lines);
        join_none
        repeat (120 * lines) @(posedge clk) #1 n += (frameMarked === 1'b1);
        wait fork;
    endtask : frameSeen

    ////////////////////////////////////////////////////////////////////////////////

    task automatic tReset();
        rdChk("command", ADDR_COMMAND, 32'h3, 32'h0);
        rdChk("control", ADDR_CONTROL, 32'hfff, {20'h0, CTL_RESET});
        rdChk("status", ADDR_STATUS, 32'hf, 32'h0);
        rdChk("unmapped", 4'h9, 32'hffffffff, 32'h0);
    endtask : tReset

    task automatic tSnap();
        fork
            cam.frame(3);
        join_none
        tick(60);
        wr(ADDR_COMMAND, {30'h0, CMD_SNAP});
        tick(20);
        chk("mid-frame start", 32'h0, {31'h0, frameMarked});
        wait fork;
        rdChk("command", ADDR_COMMAND, 32'h3, {30'h0, CMD_SNAP});
        fork
            cam.frame(3);
        join_none
        waitMark(1'b1, 200);
        rdChk("status", ADDR_STATUS, 32'h3, {30'h0, CMD_SNAP});
        rdChk("command", ADDR_COMMAND, 32'h3, {30'h0, CMD_FREEZE});
        wait fork;
        waitMark(1'b0, 20);
        frameSeen(2, seen);
        chk("snap extra", 32'h0, seen);
    endtask : tSnap

    task automatic tGrabAbort();
        wr(ADDR_COMMAND, {30'h0, CMD_GRAB});
        fork
            cam.frame(4);
        join_none
        waitMark(1'b1, 200);
        wr(ADDR_COMMAND, {30'h0, CMD_SNAP});
        rdChk("command", ADDR_COMMAND, 32'h3, {30'h0, CMD_GRAB});
        wr(ADDR_COMMAND, {30'h0, CMD_ABORT});
        waitMark(1'b0, 10);
        chk("mid frame", 32'h1, {31'h0, fv});
        chk("abort clear", 32'h1, {31'h0, cnt < 14'h10});
        rdChk("status", ADDR_STATUS, 32'h3, {30'h0, CMD_ABORT});
        wait fork;
        wr(ADDR_COMMAND, {30'h0, CMD_FREEZE});
    endtask : tGrabAbort

    task automatic tFreeze();
        wr(ADDR_COMMAND, {30'h0, CMD_GRAB});
        cam.frame(1);
        wr(ADDR_COMMAND, {30'h0, CMD_FREEZE});
        rdChk("between frames", ADDR_STATUS, 32'hf, 32'h0);
        wr(ADDR_COMMAND, {30'h0, CMD_GRAB});
        fork
            cam.frame(4);
        join_none
        waitMark(1'b1, 200);
        wr(ADDR_COMMAND, {30'h0, CMD_FREEZE});
        seen = 0;
        repeat (100) @(posedge clk) #1 seen += (frameMarked === 1'b1);
        chk("freeze holds", 32'd100, seen);
        wait fork;
        waitMark(1'b0, 20);
        frameSeen(2, seen);
        chk("after freeze", 32'h0, seen);
    endtask : tFreeze

    task automatic tAbortSrc();
        wr(ADDR_CONTROL, ctl(MODE_NEXT_FRAME, 1'b1, 1'b0, 1'b0, CLEAR_END_WINDOW, JUMP_NONE));
        cam.setTrigger(1'b1);
        wr(ADDR_COMMAND, {30'h0, CMD_GRAB});
        fork
            cam.frame(4);
        join_none
        waitMark(1'b1, 200);
        cam.setTrigger(1'b0);
        waitMark(1'b0, 30);
        chk("mid frame", 32'h1, {31'h0, fv});
        wr(ADDR_COMMAND, {30'h0, CMD_FREEZE});
        wr(ADDR_CONTROL, 32'h0);
        wait fork;
    endtask : tAbortSrc

    task automatic tTrigMode(input logic [2:0] mode, input capture_cmd_t c, expCmd);
        wr(ADDR_CONTROL, ctl(mode, 1'b0, 1'b0, 1'b0, CLEAR_END_WINDOW, JUMP_NONE));
        wr(ADDR_COMMAND, {30'h0, c});
        frameSeen(3, seen);
        chk("untriggered", 32'h0, seen);
        cam.setTrigger(1'b1);
        frameSeen(3, seen);
        chk("triggered", 32'h1, {31'h0, seen > 0});
        cam.setTrigger(1'b0);
        frameSeen(3, seen);
        chk("no retrigger", 32'h0, seen);
        rdChk("command", ADDR_COMMAND, 32'h3, {30'h0, expCmd});
        wr(ADDR_COMMAND, {30'h0, CMD_ABORT});
        wr(ADDR_COMMAND, {30'h0, CMD_FREEZE});
        wr(ADDR_CONTROL, 32'h0);
    endtask : tTrigMode

    task automatic tMode3();
        wr(ADDR_CONTROL, ctl(MODE_TRIG_LEVEL, 1'b0, 1'b0, 1'b0, CLEAR_END_WINDOW, JUMP_NONE));
        wr(ADDR_COMMAND, {30'h0, CMD_GRAB});
        rdChk("command", ADDR_COMMAND, 32'h3, {30'h0, CMD_FREEZE});
        cam.setTrigger(1'b1);
        fork
            cam.frame(4);
        join_none
        waitMark(1'b1, 200);
        cam.setTrigger(1'b0);
        waitMark(1'b0, 30);
        wait fork;
        wr(ADDR_CONTROL, 32'h0);
    endtask : tMode3

    task automatic tCounter();
        wr(ADDR_CONTROL, ctl(MODE_NEXT_FRAME, 1'b0, 1'b1, 1'b0, CLEAR_TABLE, JUMP_ENCODER));
        pulse(2);
        tick(10);
        chk("held zero", 32'h0, {18'h0, cnt});
        cam.encPulse();
        tick(10);
        chk("released", 32'h1, {31'h0, cnt != 14'h0 && cnt < JUMP_VALUE});
        @(posedge clk) loadEn <= 1'b1;
        cam.encPulse();
        tick(10);
        chk("jump", 32'h1, {31'h0, cnt >= JUMP_VALUE && cnt < 14'h2040});
        pulse(0);
        tick(3);
        chk("no window clear", 32'h1, {31'h0, cnt >= JUMP_VALUE});
        pulse(1);
        tick(3);
        chk("table clear", 32'h0, {18'h0, cnt});
        @(posedge clk) loadEn <= 1'b0;
        wr(ADDR_CONTROL, ctl(MODE_NEXT_FRAME, 1'b0, 1'b0, 1'b1, CLEAR_END_WINDOW, JUMP_NONE));
        pulse(0);
        tick(2);
        chk("window clear", 32'h1, {31'h0, cnt < 14'h8});
        tick(8300);
        chk("stick", {18'h0, STICK_POINT}, {18'h0, cnt});
        pulse(0);
        tick(2);
        chk("stick release", 32'h1, {31'h0, cnt < 14'h8});
        wr(ADDR_CONTROL, ctl(MODE_NEXT_FRAME, 1'b0, 1'b0, 1'b0, CLEAR_FRAME_OR_TABLE,
            JUMP_LINE_VALID));
        tick(300);
        cam.frame(1);
        chk("frame clear", 32'h1, {31'h0, cnt < 14'h100});
        @(posedge clk) loadEn <= 1'b1;
        cam.frame(1);
        chk("line jump", 32'h1, {31'h0, cnt >= JUMP_VALUE && cnt < 14'h2100});
        @(posedge clk) loadEn <= 1'b0;
    endtask : tCounter

    ////////////////////////////////////////////////////////////////////////////////

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            errTotal++;
            printVerdict();
        end
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        regAddr = 4'h0;
        regWrData = 32'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        ev = 3'h0;
        loadEn = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        tReset();
        tSnap();
        tGrabAbort();
        tFreeze();
        tAbortSrc();
        tTrigMode(MODE_TRIG_CMD, CMD_SNAP, CMD_FREEZE);
        tTrigMode(MODE_TRIG_SNAP, CMD_GRAB, CMD_GRAB);
        tMode3();
        tCounter();
        printVerdict();
    end

endmodule : tb_top
`default_nettype wire
